// *** design/ssfs_pkg.sv ***
// constants, field layout and types of the synchronous serial port
// How it works
// R1 - loop bit routes transmit back to receive
// R2 - receive fifo reset bit empties receive fifo
// R3 - status upper byte counts, lower byte flags
// R4 - parity error count at bits 15:12
// R5 - framing error count at bits 11:8
// R6 - error, break, framing, parity flags read zero
// R7 - transmit end low while sending, high after
// R8 - tx empty flag when count at or below trigger
// R9 - rx full flag when count reaches trigger
// R10 - data ready never set in synchronous mode
// R11 - overrun sticky, cleared by zero after read
// R12 - mode bit 7 selects synchronous operation
// R13 - synchronous characters always eight bits
// R14 - no parity generated or checked synchronously
// R15 - odd/even bit ignored without parity
// R16 - no stop bits, stop length ignored
// R17 - two-bit field picks generator clock, 00 undivided
// R18 - eight-bit rate register sets bit rate
// R19 - port data bit drives general output pin
// R20 - three-bit function field, 010 selects serial
// R21 - direction bit one output, zero input
// R22 - four-bit priority field for serial requests
// R23 - trigger code 00 means rx 1, tx 8
// R24 - tx interrupt enable gates empty, rx interrupt enable the rest
// R25 - request high only while flag and enable
package ssfs_pkg;
	localparam int ADDR_W = 4;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] A_MODE = 4'h0;
	localparam logic [3:0] A_BRR = 4'h1;
	localparam logic [3:0] A_CTRL = 4'h2;
	localparam logic [3:0] A_TXD = 4'h3;
	localparam logic [3:0] A_STAT = 4'h4;
	localparam logic [3:0] A_RXD = 4'h5;
	localparam logic [3:0] A_FCR = 4'h6;
	localparam logic [3:0] A_LSR = 4'h7;
	localparam logic [3:0] A_PDR = 4'h8;
	localparam logic [3:0] A_PFC = 4'h9;
	localparam logic [3:0] A_PIOR = 4'hA;
	localparam logic [3:0] A_IPR = 4'hB;
	localparam int MODE_SYNC = 7;
	localparam int MODE_PE = 5;
	localparam int MODE_CKS = 0;
	localparam int CTRL_TIE = 7;
	localparam int CTRL_RIE = 6;
	localparam int CTRL_TE = 5;
	localparam int CTRL_RE = 4;
	localparam int FCR_RTRG = 6;
	localparam int FCR_TTRG = 4;
	localparam int FCR_TFRST = 2;
	localparam int FCR_RX_FIFO_RESET = 1;
	localparam int FCR_LOOP = 0;
	localparam int ST_PER_CNT = 12;
	localparam int ST_FER_CNT = 8;
	localparam int ST_ER = 7;
	localparam int ST_TX_END_FLAG = 6;
	localparam int ST_TX_FIFO_EMPTY_FLAG = 5;
	localparam int ST_BRK = 4;
	localparam int ST_FER = 3;
	localparam int ST_PER = 2;
	localparam int ST_RDF = 1;
	localparam int ST_DR = 0;
	localparam int LSR_OVERRUN_FLAG = 0;
	localparam int PIN_RX = 4;
	localparam int PIN_TX = 5;
	localparam int PIN_SCK = 6;
	localparam logic [2:0] FN_SERIAL = 3'h2;
	localparam int IPR_LVL = 0;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [7:0] BRR_RST = 8'hFF;
	// trigger numbers indexed by the two-bit select code
	localparam logic [4:0] RX_TRIG [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
	localparam logic [4:0] TX_TRIG [4] = '{5'h08, 5'h04, 5'h02, 5'h00};
	// interrupt requests and their priority level
	typedef struct packed {
		logic tx_empty;
		logic rx_full;
		logic rx_error;
		logic break_detect_flag;
		logic [3:0] level;
	} ssfs_irq_t;
	// all state of the top module
	typedef struct packed {
		logic [15:0] mode;
		logic [7:0] brr;
		logic [15:0] ctrl;
		logic [15:0] fcr;
		logic overrun_flag;
		logic overrun_flag_seen;
		logic [15:0] pdr;
		logic [15:0] pfc;
		logic [15:0] pior;
		logic [15:0] ipr;
		logic [15:0] rdata;
		logic busy;
		logic [2:0] bit_cnt;
		logic sck;
		logic txd;
		logic [7:0] tx_sh;
		logic [7:0] rx_sh;
		logic [15:0] pin_m;
		logic [15:0] pin_s;
	} ssfs_state_t;
endpackage : ssfs_pkg

// *** design/ssfs_fifo.sv ***
// byte fifo in flip-flops with flush and fill count
module ssfs_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // async reset, low
	input wire logic flush_i, // empties the fifo
	input wire logic push_valid_i, // write request
	output logic push_ready_o, // room left
	input wire logic [W-1:0] push_data_i, // write data
	output logic pop_valid_o, // data present
	input wire logic pop_ready_i, // read request
	output logic [W-1:0] pop_data_o, // head entry
	output logic [$clog2(DEPTH):0] count_o // entries held
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} ssfs_fifo_st_t;
	ssfs_fifo_st_t q, d;
	logic do_push, do_pop;

	assign push_ready_o = (q.cnt != (AW+1)'(DEPTH));
	assign pop_valid_o = (q.cnt != '0);
	assign pop_data_o = q.mem[q.rp];
	assign count_o = q.cnt;
	assign do_push = push_valid_i && push_ready_o;
	assign do_pop = pop_ready_i && pop_valid_o;

	// flush wins over any push or pop in the same cycle
	always_comb begin
		d = q;
		if (do_push) begin
			d.mem[q.wp] = push_data_i;
			d.wp = q.wp + 1'b1;
		end
		if (do_pop) begin
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (flush_i) begin
			d.wp = '0;
			d.rp = '0;
			d.cnt = '0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : ssfs_fifo

// *** design/ssfs_brg.sv ***
// bit-rate generator: prescaler then rate counter, one-cycle tick out
module ssfs_brg (
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // async reset, low
	input wire logic run_i, // counts only while a transfer runs
	input wire logic [1:0] cks_i, // prescale select
	input wire logic [7:0] brr_i, // rate value
	output logic tick_o // half-bit pulse
);
	typedef struct packed {
		logic [5:0] pre;
		logic [7:0] cnt;
	} ssfs_brg_st_t;
	ssfs_brg_st_t q, d;
	logic [5:0] pre_top;
	logic pre_en;

	// prescale 1, 4, 16 or 64; code 00 is the undivided clock
	assign pre_top = 6'((1 << (2 * cks_i)) - 1); // see R17
	assign pre_en = (q.pre == pre_top);
	assign tick_o = run_i && pre_en && (q.cnt == brr_i); // see R18

	// restart from zero when idle so the first half bit is full length
	always_comb begin
		d = q;
		if (!run_i) begin
			d = '0;
		end else begin
			d.pre = pre_en ? 6'h00 : q.pre + 6'h01;
			if (pre_en) begin
				d.cnt = (q.cnt == brr_i) ? 8'h00 : q.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : ssfs_brg

// *** design/ssfs_top.sv ***
// synchronous serial port with fifos, status, port pins and requests
module ssfs_top (
	input wire logic clk_i, // 200 MHz core clock
	input wire logic rst_n_i, // async reset, low
	input wire logic [3:0] addr_i, // register address
	input wire logic [15:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [15:0] rdata_o, // read data, next cycle
	input wire logic [15:0] pin_i, // port pin levels
	output logic [15:0] pin_o, // port pin drive values
	output logic [15:0] pin_oe_o, // port pin enables
	output ssfs_pkg::ssfs_irq_t irq_o // requests and level
);
	ssfs_pkg::ssfs_state_t q, d;

	logic tick;
	logic sync_mode;
	logic tx_en, rx_en;
	logic loop_en;
	logic rx_bit;
	logic start;
	logic done;
	logic [4:0] tx_cnt, rx_cnt;
	logic tx_valid, rx_push_ready;
	logic [7:0] tx_head, rx_head;
	logic rx_valid;
	logic rx_pop;
	logic tx_push;
	logic [4:0] rx_trig, tx_trig;
	logic tx_fifo_empty_flag, rx_fifo_full_flag, tx_end_flag;
	logic [3:0] per_cnt, fer_cnt;
	logic er_flag, brk_flag, fer_flag, per_flag;
	logic [15:0] status;
	logic [3:0] is_serial;
	logic wr_lsr_clear;

	// mode decode; async framing is not built, so the engine
	// only runs with the synchronous mode bit set
	assign sync_mode = q.mode[ssfs_pkg::MODE_SYNC]; // see R12
	assign tx_en = sync_mode && q.ctrl[ssfs_pkg::CTRL_TE];
	assign rx_en = sync_mode && q.ctrl[ssfs_pkg::CTRL_RE];
	assign loop_en = q.fcr[ssfs_pkg::FCR_LOOP];

	// in loop-back the receiver hears the shifter's own output;
	// there are no handshake pins in this port to tie together
	assign rx_bit = loop_en ? q.txd : q.pin_s[ssfs_pkg::PIN_RX]; // see R1

	// one byte moves per transfer: transmit data when present,
	// or a receive-only byte while the transmitter is off;
	// done is the rising tick that samples bit 7, so the pushed
	// byte already holds the last received bit
	assign start = !q.busy && ((tx_en && tx_valid) || (rx_en && !tx_en));
	assign done = q.busy && tick && !q.sck && (q.bit_cnt == 3'h7);

	ssfs_brg u_brg (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.run_i(q.busy),
		.cks_i(q.mode[ssfs_pkg::MODE_CKS +: 2]),
		.brr_i(q.brr),
		.tick_o(tick)
	);

	assign tx_push = wr_i && (addr_i == ssfs_pkg::A_TXD);
	assign rx_pop = rd_i && (addr_i == ssfs_pkg::A_RXD);

	ssfs_fifo #(
		.W(8),
		.DEPTH(ssfs_pkg::FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(q.fcr[ssfs_pkg::FCR_TFRST]),
		.push_valid_i(tx_push),
		.push_ready_o(),
		.push_data_i(wdata_i[7:0]),
		.pop_valid_o(tx_valid),
		.pop_ready_i(start && tx_en),
		.pop_data_o(tx_head),
		.count_o(tx_cnt)
	);

	// a set reset bit holds the receive fifo empty
	ssfs_fifo #(
		.W(8),
		.DEPTH(ssfs_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(q.fcr[ssfs_pkg::FCR_RX_FIFO_RESET]), // see R2
		.push_valid_i(done && rx_en),
		.push_ready_o(rx_push_ready),
		.push_data_i({rx_bit, q.rx_sh[7:1]}),
		.pop_valid_o(rx_valid),
		.pop_ready_i(rx_pop),
		.pop_data_o(rx_head),
		.count_o(rx_cnt)
	);

	// trigger numbers from the fifo control select codes
	assign rx_trig = ssfs_pkg::RX_TRIG[q.fcr[ssfs_pkg::FCR_RTRG +: 2]]; // see R23
	assign tx_trig = ssfs_pkg::TX_TRIG[q.fcr[ssfs_pkg::FCR_TTRG +: 2]]; // see R23

	// live level flags, recomputed from fifo fill every cycle
	assign tx_fifo_empty_flag = (tx_cnt <= tx_trig); // see R8
	assign rx_fifo_full_flag = (rx_cnt >= rx_trig); // see R9
	assign tx_end_flag = !q.busy && !tx_valid; // see R7

	// no parity and no stop bit exist in synchronous frames, so
	// no parity, framing or break condition can arise; the parity
	// enable and odd/even bits are never looked at
	assign per_cnt = 4'h0; // see R4, R14, R15
	assign fer_cnt = 4'h0; // see R5, R16
	assign per_flag = 1'b0; // see R6, R14
	assign fer_flag = 1'b0; // see R6, R16
	assign brk_flag = 1'b0; // see R6
	assign er_flag = per_flag || fer_flag; // see R6

	// upper byte error counts, lower byte state flags
	always_comb begin
		status = ssfs_pkg::REG_RST;
		status[ssfs_pkg::ST_PER_CNT +: 4] = per_cnt; // see R3, R4
		status[ssfs_pkg::ST_FER_CNT +: 4] = fer_cnt; // see R3, R5
		status[ssfs_pkg::ST_ER] = er_flag;
		status[ssfs_pkg::ST_TX_END_FLAG] = tx_end_flag;
		status[ssfs_pkg::ST_TX_FIFO_EMPTY_FLAG] = tx_fifo_empty_flag;
		status[ssfs_pkg::ST_BRK] = brk_flag;
		status[ssfs_pkg::ST_FER] = fer_flag;
		status[ssfs_pkg::ST_PER] = per_flag;
		status[ssfs_pkg::ST_RDF] = rx_fifo_full_flag;
		status[ssfs_pkg::ST_DR] = 1'b0; // see R10
	end

	// which of pins 4..7 are given to the serial port
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_fn
			assign is_serial[gi] = (q.pfc[gi*4 +: 3] == ssfs_pkg::FN_SERIAL); // see R20
		end
	endgenerate

	// a zero write clears overrun only once it was read as one
	assign wr_lsr_clear = wr_i && (addr_i == ssfs_pkg::A_LSR) &&
		!wdata_i[ssfs_pkg::LSR_OVERRUN_FLAG] && q.overrun_flag_seen; // see R11

	// next-state logic for registers, engine and pin sampling
	always_comb begin
		d = q;
		// pins come from outside: two stages before use
		d.pin_m = pin_i;
		d.pin_s = q.pin_m;

		// register writes
		if (wr_i) begin
			unique case (addr_i)
				ssfs_pkg::A_MODE: d.mode = wdata_i;
				ssfs_pkg::A_BRR: d.brr = wdata_i[7:0]; // see R18
				ssfs_pkg::A_CTRL: d.ctrl = wdata_i;
				ssfs_pkg::A_FCR: d.fcr = wdata_i;
				ssfs_pkg::A_PDR: d.pdr = wdata_i; // see R19
				ssfs_pkg::A_PFC: d.pfc = wdata_i;
				ssfs_pkg::A_PIOR: d.pior = wdata_i; // see R21
				ssfs_pkg::A_IPR: d.ipr = wdata_i; // see R22
				default: d.mode = q.mode;
			endcase
		end

		// overrun: a one write does nothing; read-while-set arms the clear
		if (rd_i && (addr_i == ssfs_pkg::A_LSR) && q.overrun_flag) begin
			d.overrun_flag_seen = 1'b1;
		end
		if (wr_lsr_clear) begin
			d.overrun_flag = 1'b0;
			d.overrun_flag_seen = 1'b0;
		end
		// a new overrun in the clearing cycle wins
		if (done && rx_en && !rx_push_ready) begin
			d.overrun_flag = 1'b1; // see R11
		end

		// read data, held for exactly the cycle after the strobe
		d.rdata = ssfs_pkg::REG_RST;
		if (rd_i) begin
			unique case (addr_i)
				ssfs_pkg::A_MODE: d.rdata = q.mode;
				ssfs_pkg::A_BRR: d.rdata = {8'h00, q.brr};
				ssfs_pkg::A_CTRL: d.rdata = q.ctrl;
				ssfs_pkg::A_STAT: d.rdata = status;
				ssfs_pkg::A_RXD: d.rdata = {8'h00, rx_valid ? rx_head : 8'h00};
				ssfs_pkg::A_FCR: d.rdata = q.fcr;
				ssfs_pkg::A_LSR: d.rdata = {15'h0000, q.overrun_flag};
				ssfs_pkg::A_PDR: d.rdata = (q.pdr & q.pior) | (q.pin_s & ~q.pior);
				ssfs_pkg::A_PFC: d.rdata = q.pfc;
				ssfs_pkg::A_PIOR: d.rdata = q.pior;
				ssfs_pkg::A_IPR: d.rdata = q.ipr;
				default: d.rdata = ssfs_pkg::REG_RST;
			endcase
		end

		// shift engine: clock idles high, data changes on the falling
		// edge and is sampled on the rising edge, lsb first
		if (start) begin
			d.busy = 1'b1;
			d.bit_cnt = 3'h0;
			d.sck = 1'b1;
			d.tx_sh = tx_en ? tx_head : 8'hFF;
		end else if (q.busy && tick) begin
			if (q.sck) begin
				d.sck = 1'b0;
				d.txd = q.tx_sh[0];
			end else begin
				d.sck = 1'b1;
				d.rx_sh = {rx_bit, q.rx_sh[7:1]};
				d.tx_sh = {1'b1, q.tx_sh[7:1]};
				d.bit_cnt = q.bit_cnt + 3'h1;
				// eight bits then stop, with no parity or stop bit
				if (q.bit_cnt == 3'h7) begin
					d.busy = 1'b0; // see R13, R16
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.brr <= ssfs_pkg::BRR_RST;
			q.sck <= 1'b1;
			q.txd <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;

	// pin drive: serial functions on 4..6, port data elsewhere
	always_comb begin
		pin_o = q.pdr; // see R19
		pin_oe_o = q.pior; // see R21
		if (is_serial[ssfs_pkg::PIN_SCK - 4]) begin
			pin_o[ssfs_pkg::PIN_SCK] = q.sck;
		end
		if (is_serial[ssfs_pkg::PIN_TX - 4]) begin
			pin_o[ssfs_pkg::PIN_TX] = loop_en ? 1'b1 : q.txd;
		end
		if (is_serial[ssfs_pkg::PIN_RX - 4]) begin
			pin_oe_o[ssfs_pkg::PIN_RX] = 1'b0;
		end
	end

	// requests follow flag and enable with no latching of their own
	assign irq_o.tx_empty = q.ctrl[ssfs_pkg::CTRL_TIE] && tx_fifo_empty_flag; // see R24, R25
	assign irq_o.rx_full = q.ctrl[ssfs_pkg::CTRL_RIE] && rx_fifo_full_flag; // see R24, R25
	assign irq_o.rx_error = q.ctrl[ssfs_pkg::CTRL_RIE] && (er_flag || q.overrun_flag); // see R24, R25
	assign irq_o.break_detect_flag = q.ctrl[ssfs_pkg::CTRL_RIE] && brk_flag; // see R24, R25
	assign irq_o.level = q.ipr[ssfs_pkg::IPR_LVL +: 4]; // see R22
endmodule : ssfs_top

// *** tb/ssfs_props.sv ***
// checker on the top-level ports of the synchronous serial port
module ssfs_props (
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // async reset, low
	input wire logic [3:0] addr_i, // register address
	input wire logic [15:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [15:0] rdata_o, // read data
	input wire logic [15:0] pin_i, // pin levels
	input wire logic [15:0] pin_o, // pin values
	input wire logic [15:0] pin_oe_o, // pin enables
	input wire ssfs_pkg::ssfs_irq_t irq_o // requests
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ctrl_q;
	logic [15:0] pdr_q;
	logic [15:0] pfc_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// shadow copies of written registers, so gating can be judged from the bus alone
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= 16'h0000;
			pdr_q <= 16'h0000;
			pfc_q <= 16'h0000;
		end else if (wr_i) begin
			if (addr_i == ssfs_pkg::A_CTRL) ctrl_q <= wdata_i;
			if (addr_i == ssfs_pkg::A_PDR) pdr_q <= wdata_i;
			if (addr_i == ssfs_pkg::A_PFC) pfc_q <= wdata_i;
		end
	end
	a_level_follows: assert property (wr_i && addr_i == ssfs_pkg::A_IPR
		|=> irq_o.level == $past(wdata_i[3:0])) else $error("priority level wrong");
	a_break_quiet: assert property (!irq_o.break_detect_flag) else $error("break request raised");
	a_stat_zero: assert property (rd_i && addr_i == ssfs_pkg::A_STAT
		|=> rdata_o[15:8] == 8'h00 && rdata_o[4:2] == 3'h0) else $error("error fields set");
	a_ready_never: assert property (rd_i && addr_i == ssfs_pkg::A_STAT
		|=> !rdata_o[ssfs_pkg::ST_DR]) else $error("data ready set");
	a_lsr_reserved: assert property (rd_i && addr_i == ssfs_pkg::A_LSR
		|=> rdata_o[15:1] == 15'h0000) else $error("line status upper bits set");
	// the receive pin given to the serial port stays an input whatever its direction bit
	a_dir_enable: assert property (wr_i && addr_i == ssfs_pkg::A_PIOR
		|=> pin_oe_o[15:5] == $past(wdata_i[15:5]) && pin_oe_o[3:0] == $past(wdata_i[3:0])
		&& pin_oe_o[4] == ($past(wdata_i[4]) && pfc_q[2:0] != ssfs_pkg::FN_SERIAL))
		else $error("enables differ from direction");
	a_gpio_value: assert property (pin_o[15:8] == pdr_q[15:8]
		&& (pfc_q[14:12] != 3'h0 || pin_o[7] == pdr_q[7])) else $error("port pin value wrong");
	a_tx_gate: assert property (irq_o.tx_empty |-> ctrl_q[ssfs_pkg::CTRL_TIE])
		else $error("tx request without enable");
	a_rx_gate: assert property (irq_o.rx_full || irq_o.rx_error
		|-> ctrl_q[ssfs_pkg::CTRL_RIE]) else $error("rx request without enable");
	c_rx_full: cover property (irq_o.rx_full);
	c_rx_error: cover property (irq_o.rx_error);
	c_tx_empty: cover property (irq_o.tx_empty);
endmodule : ssfs_props
bind ssfs_top ssfs_props ssfs_props_inst (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .pin_i, .pin_o, .pin_oe_o, .irq_o);

// *** tb/ssfs_partner.sv ***
// serial partner: shifts a byte onto rx, captures tx, times the low clock half
module ssfs_partner (
	input wire logic clk_i, // bench clock
	input wire logic sck_i, // serial clock from the port
	input wire logic txd_i, // transmit line
	input wire logic [7:0] send_i, // byte to shift out
	output logic rx_o, // receive line
	output logic [7:0] got_o, // last eight bits captured
	output int bits_o, // rising clock edges seen
	output int half_o // cycles from fall to rise
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sck_q = 1'b1;
	int idx = 0;
	int t = 0;
	int t0 = 0;
	int quiet = 0;
	initial begin
		rx_o = 1'b0;
		got_o = 8'h00;
		bits_o = 0;
		half_o = 0;
	end
	// change on the fall, capture on the rise, lsb first
	always @(posedge clk_i) begin
		t <= t + 1;
		sck_q <= sck_i;
		// a long high clock means the next fall opens a new byte; this drops
		// the stray edges seen while the pins are still being configured
		if (sck_q && sck_i) quiet <= quiet + 1;
		else quiet <= 0;
		if (quiet == 16) idx <= 0;
		if (sck_q && !sck_i) begin
			rx_o <= send_i[idx];
			idx <= (idx + 1) % 8;
			t0 <= t;
		end
		if (!sck_q && sck_i) begin
			got_o <= {txd_i, got_o[7:1]};
			bits_o <= bits_o + 1;
			half_o <= t - t0;
			// between bytes the line must not keep showing a valid bit
			if (idx == 0) rx_o <= ~rx_o;
		end
	end
endmodule : ssfs_partner

// *** tb/ssfs_top_bench.sv ***
// bench for the synchronous serial port: bus tasks and scenario sequence
module ssfs_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] rdata_o;
	logic [15:0] pin_o;
	logic [15:0] pin_oe_o;
	logic [15:0] pin_i;
	logic [7:0] got;
	logic rx;
	ssfs_pkg::ssfs_irq_t irq_o;
	int bits;
	int half;
	int b0;
	int i;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	assign pin_i = {11'h091, rx, 4'h0};
	always #2.5 clk_i = ~clk_i;
	ssfs_top ssfs_top_inst (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.pin_i, .pin_o, .pin_oe_o, .irq_o);
	ssfs_partner ssfs_partner_inst (.clk_i, .sck_i(pin_o[6]), .txd_i(pin_o[5]),
		.send_i(8'h3C), .rx_o(rx), .got_o(got), .bits_o(bits), .half_o(half));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one-cycle write strobe; the extra delay lets outputs settle before checks
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] m, output logic [15:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		v = rdata_o & m;
	endtask : rd
	task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] v;
		rd(a, m, v);
		chk(v, e);
	endtask : rdc
	// poll status until a masked flag shows, bounded
	task automatic waitst(input logic [15:0] m);
		logic [15:0] v;
		v = 16'h0000;
		for (int k = 0; k < 400 && v == 16'h0000; k++) rd(ssfs_pkg::A_STAT, m, v);
	endtask : waitst
	task automatic print_verdict;
		$display("errors=%0d checks=%0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// hang guard, far above the roughly one thousand cycles the sequence needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdc(ssfs_pkg::A_STAT, 16'hFF3F, 16'h0020);
		rdc(ssfs_pkg::A_BRR, 16'h00FF, 16'h00FF);
		rdc(ssfs_pkg::A_LSR, 16'hFFFF, 16'h0000);
		rdc(ssfs_pkg::A_PDR, 16'hFFEF, 16'h1220);
		wr(4'hF, 16'hFFFF);
		rdc(4'hF, 16'hFFFF, 16'h0000);
		wr(ssfs_pkg::A_PDR, 16'h8040);
		wr(ssfs_pkg::A_PIOR, 16'h8060);
		wr(ssfs_pkg::A_PFC, 16'h0222);
		wr(ssfs_pkg::A_IPR, 16'h000F);
		chk(pin_oe_o, 16'h8060);
		chk(16'(irq_o.level), 16'h000F);
		chk(16'(pin_o[15]), 16'h0001);
		chk(16'(pin_o[6]), 16'h0001);
		rdc(ssfs_pkg::A_PFC, 16'hFFFF, 16'h0222);
		rdc(ssfs_pkg::A_PDR, 16'hFFEF, 16'h9240);
		// format bits set but ignored in synchronous mode
		wr(ssfs_pkg::A_BRR, 16'h0003);
		wr(ssfs_pkg::A_MODE, 16'h00F8);
		rdc(ssfs_pkg::A_MODE, 16'hFFFF, 16'h00F8);
		wr(ssfs_pkg::A_CTRL, 16'h0030);
		b0 = bits;
		wr(ssfs_pkg::A_TXD, 16'h00A5);
		rdc(ssfs_pkg::A_STAT, 16'h0040, 16'h0000);
		waitst(16'h0002);
		rdc(ssfs_pkg::A_STAT, 16'h0063, 16'h0062);
		chk(16'(got), 16'h00A5);
		chk(16'(bits - b0), 16'h0008);
		chk(16'(half), 16'h0004);
		rdc(ssfs_pkg::A_RXD, 16'h00FF, 16'h003C);
		rdc(ssfs_pkg::A_STAT, 16'h0002, 16'h0000);
		// asynchronous mode is not built, so nothing may move on the pins
		wr(ssfs_pkg::A_MODE, 16'h0078);
		b0 = bits;
		wr(ssfs_pkg::A_TXD, 16'h0011);
		repeat (150) @(posedge clk_i);
		chk(16'(bits - b0), 16'h0000);
		wr(ssfs_pkg::A_FCR, 16'h0004);
		wr(ssfs_pkg::A_FCR, 16'h0000);
		wr(ssfs_pkg::A_MODE, 16'h0080);
		// transmit trigger boundary: eight bytes flag empty, nine do not
		wr(ssfs_pkg::A_CTRL, 16'h0080);
		for (i = 0; i < 8; i++) wr(ssfs_pkg::A_TXD, 16'(i));
		rdc(ssfs_pkg::A_STAT, 16'h0020, 16'h0020);
		chk(16'(irq_o.tx_empty), 16'h0001);
		wr(ssfs_pkg::A_TXD, 16'h0008);
		rdc(ssfs_pkg::A_STAT, 16'h0020, 16'h0000);
		chk(16'(irq_o.tx_empty), 16'h0000);
		wr(ssfs_pkg::A_FCR, 16'h0004);
		wr(ssfs_pkg::A_FCR, 16'h0000);
		chk(16'(irq_o.tx_empty), 16'h0001);
		wr(ssfs_pkg::A_CTRL, 16'h0000);
		chk(16'(irq_o.tx_empty), 16'h0000);
		// receive only: the fifo fills and the next byte overruns
		wr(ssfs_pkg::A_BRR, 16'h0000);
		wr(ssfs_pkg::A_CTRL, 16'h0050);
		for (i = 0; i < 2000 && irq_o.rx_error !== 1'b1; i++) @(posedge clk_i);
		#1;
		chk(16'(irq_o.rx_error), 16'h0001);
		chk(16'(irq_o.rx_full), 16'h0001);
		wr(ssfs_pkg::A_CTRL, 16'h0040);
		repeat (100) @(posedge clk_i);
		wr(ssfs_pkg::A_LSR, 16'h0000);
		rdc(ssfs_pkg::A_LSR, 16'hFFFF, 16'h0001);
		wr(ssfs_pkg::A_LSR, 16'h0000);
		rdc(ssfs_pkg::A_LSR, 16'hFFFF, 16'h0000);
		wr(ssfs_pkg::A_LSR, 16'h0001);
		rdc(ssfs_pkg::A_LSR, 16'hFFFF, 16'h0000);
		chk(16'(irq_o.rx_error), 16'h0000);
		wr(ssfs_pkg::A_FCR, 16'h0002);
		wr(ssfs_pkg::A_FCR, 16'h0000);
		rdc(ssfs_pkg::A_STAT, 16'h0002, 16'h0000);
		chk(16'(irq_o.rx_full), 16'h0000);
		rdc(ssfs_pkg::A_RXD, 16'hFFFF, 16'h0000);
		// loop-back with the divided generator clock
		wr(ssfs_pkg::A_FCR, 16'h0001);
		wr(ssfs_pkg::A_MODE, 16'h00F9);
		wr(ssfs_pkg::A_BRR, 16'h0001);
		wr(ssfs_pkg::A_CTRL, 16'h0030);
		wr(ssfs_pkg::A_TXD, 16'h005A);
		waitst(16'h0002);
		rdc(ssfs_pkg::A_RXD, 16'h00FF, 16'h005A);
		chk(16'(got), 16'h00FF);
		chk(16'(half), 16'h0008);
		print_verdict();
	end
endmodule : ssfs_top_bench
